/* File: rtl/tmc_defines.vh */
// Register offsets, field positions, reset values and mode codes of the timer block.
// Assumes a classic Wishbone slave with 32-bit aligned words.
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

`define TMC_ADR_CTRL_A 4'h0
`define TMC_ADR_CTRL_B 4'h1
`define TMC_ADR_COUNT 4'h2
`define TMC_ADR_CMP_A 4'h3
`define TMC_ADR_CMP_B 4'h4
`define TMC_ADR_FLAGS 4'h5
`define TMC_ADR_IEN 4'h6
`define TMC_ADR_PORT 4'h7
`define TMC_ADR_ACK 4'h8

// Control A: [7:6] action A, [5:4] action B, [1:0] mode bits 1:0.
`define TMC_CA_ACT_A_HI 7
`define TMC_CA_ACT_A_LO 6
`define TMC_CA_ACT_B_HI 5
`define TMC_CA_ACT_B_LO 4
// Control B: [7] force A, [6] force B, [3] mode bit 2, [2:0] clock source.
`define TMC_CB_FORCE_A 7
`define TMC_CB_FORCE_B 6
`define TMC_CB_MODE2 3
`define TMC_CB_CS_HI 2
`define TMC_CB_CS_LO 0
// Flags and enables: [0] overflow, [1] match A, [2] match B.
`define TMC_FL_OVF 0
`define TMC_FL_MA 1
`define TMC_FL_MB 2
// Port register: [0] port value A, [1] port value B, [2] dir A, [3] dir B.
`define TMC_PT_VAL_A 0
`define TMC_PT_VAL_B 1
`define TMC_PT_DIR_A 2
`define TMC_PT_DIR_B 3

`define TMC_BOTTOM 8'h00
`define TMC_MAX 8'hff
`define TMC_RST_BYTE 8'h00

`define TMC_MODE_NORMAL 3'h0
`define TMC_MODE_PC_MAX 3'h1
`define TMC_MODE_CTC 3'h2
`define TMC_MODE_FAST_MAX 3'h3
`define TMC_MODE_PC_OCA 3'h5
`define TMC_MODE_FAST_OCA 3'h7

`define TMC_CS_STOP 3'h0
`define TMC_CS_EXT_FALL 3'h6
`define TMC_CS_EXT_RISE 3'h7

`endif

/* File: rtl/tmc_timer.v */
// 8-bit timer/counter with two compare channels, behind a classic Wishbone slave.
// Assumes the prescaler taps and the external pin are synchronous to clk_i.
// Functional notes
// - Each active tick moves the counter by one, direction chosen separately, or clears it at top in CTC and fast PWM.
// - Per mode, the counter clears, increments or decrements once per tick.
// - Clock source select of zero produces no ticks; counter stays stopped.
// - Software may read and write the counter at any time.
// - A software counter write beats a same-cycle clear or count.
// - Mode field: two low bits in control A, high bit in control B.
// - Overflow flag set at mode-dependent points; it can raise an interrupt.
// - Top when counter reaches its top value, bottom when counter is zero.
// - Two comparators continuously compare counter with compare values A and B.
// - A match sets its match flag on the next tick.
// - Enabled set flag raises an interrupt; servicing clears it in hardware.
// - Writing one to a flag bit clears that flag.
// - Compare values double buffered in PWM modes, direct in normal and CTC.
// - Buffered compare value copied to active register only at top or bottom.
// - Software reaches the buffer when buffering, else the active register.
// - Non-PWM force strobe updates output as a match, without flag or counter effect.
// - A counter write blocks all matches in the following tick, even stopped.
// - Waveform output registers keep their value across mode changes.
// - Output action is unbuffered; new action applies from next match.
// - Reset clears each waveform output register.
// - Nonzero action makes the waveform replace port value; direction stays from port.
// - Zero action means a match leaves the waveform output unchanged.
// - Bottom is zero, max 255; top is max or compare value A.
// - Mode 0 normal, 2 CTC on compare A, 3 and 7 fast PWM.
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
`include "tmc_defines.vh"

module tmc_timer (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [6:0] presc_tick_i,
    input wire ext_pin_i,
    input wire irq_ack_ovf_i,
    input wire irq_ack_a_i,
    input wire irq_ack_b_i,
    output reg irq_ovf_o,
    output reg irq_a_o,
    output reg irq_b_o,
    output reg pin_a_o,
    output reg pin_a_oe_o,
    output reg pin_b_o,
    output reg pin_b_oe_o,
    output reg top_o,
    output reg bottom_o
);

    reg [7:0] ctrl_a_q;
    reg [2:0] cs_q;
    reg mode2_q;
    reg [7:0] count_value_q;
    reg [7:0] count_value_d;
    reg [7:0] compare_value_a_q;
    reg [7:0] compare_value_b_q;
    reg [7:0] buf_a_q;
    reg [7:0] buf_b_q;
    reg overflow_flag_q;
    reg match_flag_a_q;
    reg match_flag_b_q;
    reg [2:0] ien_q;
    reg [3:0] port_q;
    reg wave_out_a_q;
    reg wave_out_b_q;
    reg block_q;
    reg down_q;
    reg ext_q;
    reg ext_prev_q;

    wire [2:0] waveform_mode_field = {mode2_q, ctrl_a_q[1:0]};
    wire [1:0] act_a = ctrl_a_q[`TMC_CA_ACT_A_HI:`TMC_CA_ACT_A_LO];
    wire [1:0] act_b = ctrl_a_q[`TMC_CA_ACT_B_HI:`TMC_CA_ACT_B_LO];
    wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    wire [3:0] idx = wb_adr_i[5:2];
    wire [7:0] wbyte = wb_dat_i[7:0];

    // Modes 1 and 5 run phase correct; their sequencing is kept simple up/down.
    function is_pwm;
        input [2:0] m;
        begin
            is_pwm = m[0];
        end
    endfunction

    // Next waveform level for a match under a non-PWM or a PWM action code.
    function wave_match;
        input [1:0] act;
        input pwm;
        input cur;
        input down;
        begin
            if (act == 2'h0) begin
                wave_match = cur;
            end else if (act == 2'h1) begin
                wave_match = ~cur;
            end else if (!pwm) begin
                wave_match = act[0];
            end else begin
                wave_match = act[0] ^ down;
            end
        end
    endfunction

    wire pwm = is_pwm(waveform_mode_field);
    wire top_from_a = (waveform_mode_field == `TMC_MODE_CTC) ||
                      (waveform_mode_field == `TMC_MODE_PC_OCA) ||
                      (waveform_mode_field == `TMC_MODE_FAST_OCA);
    wire [7:0] top_val = top_from_a ? compare_value_a_q : `TMC_MAX;
    wire at_top = (count_value_q == top_val);
    wire at_bottom = (count_value_q == `TMC_BOTTOM);
    wire phase = (waveform_mode_field == `TMC_MODE_PC_MAX) || (waveform_mode_field == `TMC_MODE_PC_OCA);

    // Timer tick select: prescaler taps or edges of the external pin.
    reg timer_tick;
    always @* begin
        case (cs_q)
            `TMC_CS_STOP: timer_tick = 1'b0;
            `TMC_CS_EXT_FALL: timer_tick = ext_prev_q & ~ext_q;
            `TMC_CS_EXT_RISE: timer_tick = ~ext_prev_q & ext_q;
            default: timer_tick = presc_tick_i[cs_q];
        endcase
    end

    wire match_a = (count_value_q == compare_value_a_q) & ~block_q;
    wire match_b = (count_value_q == compare_value_b_q) & ~block_q;
    wire cnt_wr = wr && idx == `TMC_ADR_COUNT;
    wire force_wr = wr && idx == `TMC_ADR_CTRL_B && !pwm;

    reg next_down;
    always @* begin
        count_value_d = count_value_q;
        next_down = down_q;
        if (timer_tick) begin
            if (phase) begin
                if (at_top) begin
                    next_down = 1'b1;
                end else if (at_bottom) begin
                    next_down = 1'b0;
                end
                count_value_d = (next_down ? count_value_q - 8'h01 : count_value_q + 8'h01);
            end else if (at_top && top_from_a || at_top && pwm) begin
                count_value_d = `TMC_BOTTOM;
                next_down = 1'b0;
            end else begin
                count_value_d = count_value_q + 8'h01;
                next_down = 1'b0;
            end
        end
        if (cnt_wr) begin
            count_value_d = wbyte;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_q <= `TMC_RST_BYTE;
            cs_q <= 3'h0;
            mode2_q <= 1'b0;
            count_value_q <= `TMC_RST_BYTE;
            compare_value_a_q <= `TMC_RST_BYTE;
            compare_value_b_q <= `TMC_RST_BYTE;
            buf_a_q <= `TMC_RST_BYTE;
            buf_b_q <= `TMC_RST_BYTE;
            overflow_flag_q <= 1'b0;
            match_flag_a_q <= 1'b0;
            match_flag_b_q <= 1'b0;
            ien_q <= 3'h0;
            port_q <= 4'h0;
            wave_out_a_q <= 1'b0;
            wave_out_b_q <= 1'b0;
            block_q <= 1'b0;
            down_q <= 1'b0;
            ext_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_q <= ext_pin_i;
            ext_prev_q <= ext_q;
            count_value_q <= count_value_d;
            down_q <= next_down;
            // The block lasts until the next tick so a stopped timer still skips one match.
            if (cnt_wr) begin
                block_q <= 1'b1;
            end else if (timer_tick) begin
                block_q <= 1'b0;
            end
            if (wr && idx == `TMC_ADR_CTRL_A) begin
                ctrl_a_q <= wbyte;
            end
            if (wr && idx == `TMC_ADR_CTRL_B) begin
                cs_q <= wbyte[`TMC_CB_CS_HI:`TMC_CB_CS_LO];
                mode2_q <= wbyte[`TMC_CB_MODE2];
            end
            if (wr && idx == `TMC_ADR_IEN) begin
                ien_q <= wbyte[2:0];
            end
            if (wr && idx == `TMC_ADR_PORT) begin
                port_q <= wbyte[3:0];
            end
            // Writes reach the buffer in PWM modes, the active register otherwise.
            if (wr && idx == `TMC_ADR_CMP_A) begin
                if (pwm) begin
                    buf_a_q <= wbyte;
                end else begin
                    compare_value_a_q <= wbyte;
                    buf_a_q <= wbyte;
                end
            end
            if (wr && idx == `TMC_ADR_CMP_B) begin
                if (pwm) begin
                    buf_b_q <= wbyte;
                end else begin
                    compare_value_b_q <= wbyte;
                    buf_b_q <= wbyte;
                end
            end
            if (pwm && timer_tick && (phase ? at_top : at_bottom)) begin
                compare_value_a_q <= buf_a_q;
                compare_value_b_q <= buf_b_q;
            end
            // Flags: hardware set wins over a same-cycle software or service clear.
            if (timer_tick && match_a) begin
                match_flag_a_q <= 1'b1;
            end else if ((wr && idx == `TMC_ADR_FLAGS && wbyte[`TMC_FL_MA]) || irq_ack_a_i) begin
                match_flag_a_q <= 1'b0;
            end
            if (timer_tick && match_b) begin
                match_flag_b_q <= 1'b1;
            end else if ((wr && idx == `TMC_ADR_FLAGS && wbyte[`TMC_FL_MB]) || irq_ack_b_i) begin
                match_flag_b_q <= 1'b0;
            end
            if (timer_tick && (phase ? at_bottom : (pwm ? at_top : count_value_d == `TMC_BOTTOM &&
                    count_value_q == `TMC_MAX))) begin
                overflow_flag_q <= 1'b1;
            end else if ((wr && idx == `TMC_ADR_FLAGS && wbyte[`TMC_FL_OVF]) || irq_ack_ovf_i) begin
                overflow_flag_q <= 1'b0;
            end
            // Wave registers change only on match, force or fast PWM top; never on mode change.
            if (force_wr && wbyte[`TMC_CB_FORCE_A]) begin
                wave_out_a_q <= wave_match(act_a, 1'b0, wave_out_a_q, 1'b0);
            end else if (timer_tick && match_a) begin
                wave_out_a_q <= wave_match(act_a, pwm, wave_out_a_q, phase & down_q);
            end else if (timer_tick && pwm && !phase && at_top && act_a[1]) begin
                wave_out_a_q <= ~act_a[0];
            end
            if (force_wr && wbyte[`TMC_CB_FORCE_B]) begin
                wave_out_b_q <= wave_match(act_b, 1'b0, wave_out_b_q, 1'b0);
            end else if (timer_tick && match_b) begin
                wave_out_b_q <= wave_match(act_b, pwm, wave_out_b_q, phase & down_q);
            end else if (timer_tick && pwm && !phase && at_top && act_b[1]) begin
                wave_out_b_q <= ~act_b[0];
            end
        end
    end

    // Registered pins, interrupts and status; they trail the state by one clock.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_a_o <= 1'b0;
            pin_b_o <= 1'b0;
            pin_a_oe_o <= 1'b0;
            pin_b_oe_o <= 1'b0;
            irq_ovf_o <= 1'b0;
            irq_a_o <= 1'b0;
            irq_b_o <= 1'b0;
            top_o <= 1'b0;
            bottom_o <= 1'b0;
        end else begin
            pin_a_o <= (act_a != 2'h0) ? wave_out_a_q : port_q[`TMC_PT_VAL_A];
            pin_b_o <= (act_b != 2'h0) ? wave_out_b_q : port_q[`TMC_PT_VAL_B];
            pin_a_oe_o <= port_q[`TMC_PT_DIR_A];
            pin_b_oe_o <= port_q[`TMC_PT_DIR_B];
            irq_ovf_o <= overflow_flag_q & ien_q[`TMC_FL_OVF];
            irq_a_o <= match_flag_a_q & ien_q[`TMC_FL_MA];
            irq_b_o <= match_flag_b_q & ien_q[`TMC_FL_MB];
            top_o <= at_top;
            bottom_o <= at_bottom;
        end
    end

    // Wishbone: one answer per request, acked one clock after it, unmapped words read zero.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= 32'h0;
            if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o) begin
                case (idx)
                    `TMC_ADR_CTRL_A: wb_dat_o <= {24'h0, ctrl_a_q};
                    `TMC_ADR_CTRL_B: wb_dat_o <= {28'h0, mode2_q, cs_q};
                    `TMC_ADR_COUNT: wb_dat_o <= {24'h0, count_value_q};
                    `TMC_ADR_CMP_A: wb_dat_o <= {24'h0, pwm ? buf_a_q : compare_value_a_q};
                    `TMC_ADR_CMP_B: wb_dat_o <= {24'h0, pwm ? buf_b_q : compare_value_b_q};
                    `TMC_ADR_FLAGS: wb_dat_o <= {29'h0, match_flag_b_q, match_flag_a_q, overflow_flag_q};
                    `TMC_ADR_IEN: wb_dat_o <= {29'h0, ien_q};
                    `TMC_ADR_PORT: wb_dat_o <= {28'h0, port_q};
                    `TMC_ADR_ACK: wb_dat_o <= {30'h0, wave_out_b_q, wave_out_a_q};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the timer block: counting, flags, compare and pin logic.
// Assumes the bus model in tmc_cpu_model.sv and the bound checker.
`timescale 1ns/1ns
module tb_top;
    logic clk, rst, cyc, stb, we, ack, ack_ovf, ack_a, irq_ovf, irq_a, pa, paoe;
    logic ack_b, irq_b, pb, pboe, top, bot;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [6:0] tck;
    logic [7:0] q;
    int mismatches = 0;
    int comparisons = 0;
    tmc_cpu_model u_cpu (.clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
    tmc_timer uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .presc_tick_i(tck), .ext_pin_i(1'b0),
        .irq_ack_ovf_i(ack_ovf), .irq_ack_a_i(ack_a), .irq_ack_b_i(ack_b), .irq_ovf_o(irq_ovf), .irq_a_o(irq_a),
        .irq_b_o(irq_b), .pin_a_o(pa), .pin_a_oe_o(paoe), .pin_b_o(pb), .pin_b_oe_o(pboe), .top_o(top),
        .bottom_o(bot));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] w, input logic [7:0] d);
        u_cpu.xfer(1'b1, w, d, q);
    endtask
    task rdc(input logic [3:0] w, input logic [7:0] e);
        u_cpu.xfer(1'b0, w, 8'h00, q);
        chk(q, e);
    endtask
    task tick(input int n);
        repeat (n) begin
            @(posedge clk);
            tck <= 7'h02;
            @(posedge clk);
            tck <= 7'h00;
        end
    endtask
    // Pin and interrupt outputs are registered one stage behind the state they show.
    task settle;
        repeat (2) @(posedge clk);
    endtask
    task tally_and_finish;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task t_reset;
        rdc(4'h2, 8'h00);
        rdc(4'h8, 8'h00);
        chk({7'h00, pa}, 8'h00);
        rdc(4'h9, 8'h00);
    endtask
    task t_stop;
        wr(4'h2, 8'h10);
        wr(4'h1, 8'h00);
        tick(3);
        rdc(4'h2, 8'h10);
    endtask
    task t_count;
        wr(4'h3, 8'h80);
        wr(4'h1, 8'h01);
        tick(3);
        rdc(4'h2, 8'h13);
    endtask
    task t_ovf;
        wr(4'h6, 8'h01);
        wr(4'h2, 8'hff);
        tick(1);
        rdc(4'h2, 8'h00);
        rdc(4'h5, 8'h01);
        chk({7'h00, irq_ovf}, 8'h01);
        wr(4'h5, 8'h00);
        rdc(4'h5, 8'h01);
        @(posedge clk);
        ack_ovf <= 1'b1;
        @(posedge clk);
        ack_ovf <= 1'b0;
        settle;
        rdc(4'h5, 8'h00);
        chk({7'h00, irq_ovf}, 8'h00);
    endtask
    task t_match;
        wr(4'h3, 8'h05);
        wr(4'h2, 8'h05);
        tick(1);
        rdc(4'h5, 8'h00);
        wr(4'h2, 8'h04);
        tick(2);
        rdc(4'h5, 8'h02);
        wr(4'h5, 8'h02);
        rdc(4'h5, 8'h00);
    endtask
    task t_wave;
        wr(4'h7, 8'h04);
        wr(4'h0, 8'h40);
        wr(4'h1, 8'h80);
        settle;
        chk({6'h00, paoe, pa}, 8'h03);
        rdc(4'h8, 8'h01);
        rdc(4'h5, 8'h00);
        rdc(4'h2, 8'h06);
        wr(4'h0, 8'h43);
        rdc(4'h8, 8'h01);
        wr(4'h0, 8'h00);
        wr(4'h7, 8'h05);
        settle;
        chk({7'h00, pa}, 8'h01);
        wr(4'h7, 8'h04);
        settle;
        chk({7'h00, pa}, 8'h00);
        wr(4'h1, 8'h80);
        rdc(4'h8, 8'h01);
    endtask
    task t_ctc;
        wr(4'h0, 8'h02);
        wr(4'h3, 8'h03);
        wr(4'h6, 8'h02);
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h01);
        tick(4);
        rdc(4'h2, 8'h00);
        rdc(4'h5, 8'h02);
        chk({7'h00, irq_a}, 8'h01);
        @(posedge clk);
        ack_a <= 1'b1;
        @(posedge clk);
        ack_a <= 1'b0;
        settle;
        chk({7'h00, irq_a}, 8'h00);
    endtask
    // Fast PWM on channel B: the buffered compare value only takes over at bottom.
    task t_pwm;
        wr(4'h4, 8'h05);
        wr(4'h7, 8'h0c);
        wr(4'h6, 8'h04);
        wr(4'h0, 8'h23);
        wr(4'h4, 8'h02);
        rdc(4'h4, 8'h02);
        wr(4'h2, 8'hfe);
        tick(1);
        settle;
        chk({7'h00, top}, 8'h01);
        tick(1);
        settle;
        chk({5'h00, bot, pboe, pb}, 8'h07);
        tick(3);
        settle;
        chk({7'h00, pb}, 8'h00);
        rdc(4'h5, 8'h05);
        chk({7'h00, irq_b}, 8'h01);
        @(posedge clk);
        ack_b <= 1'b1;
        @(posedge clk);
        ack_b <= 1'b0;
        settle;
        chk({7'h00, irq_b}, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1;
        tck = 7'h00;
        ack_ovf = 1'b0;
        ack_a = 1'b0;
        ack_b = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_stop;
        t_count;
        t_ovf;
        t_match;
        t_wave;
        t_ctc;
        t_pwm;
        tally_and_finish;
    end
endmodule

/* File: testbench/tmc_cpu_model.sv */
// CPU side of the register bus: classic Wishbone single cycles, one byte per word.
// Assumes the slave answers with a one-cycle ack; the bench watchdog ends a hang.
`timescale 1ns/1ns
module tmc_cpu_model (
    input wire clk_i,
    input wire wb_ack_i,
    input wire [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [5:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 6'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // Flags are cleared by writing ones, never zeros, so software never writes stale ones back.
    task automatic xfer(input logic wr, input logic [3:0] w, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= wr;
        wb_adr_o <= {w, 2'b00};
        wb_sel_o <= 4'h1;
        wb_dat_o <= {24'h000000, d};
        do @(posedge clk_i); while (wb_ack_i !== 1'b1);
        q = wb_dat_i[7:0];
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        wb_dat_o <= ~wb_dat_o;
    endtask
endmodule

/* File: testbench/tmc_timer_props.sv */
// Checker for the timer block: bus handshake, pin enables, interrupt clearing.
// Assumes it is bound to tmc_timer and sees only that module's ports.
`timescale 1ns/1ns
module tmc_timer_props (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [6:0] presc_tick_i,
    input wire ext_pin_i,
    input wire irq_ack_a_i,
    input wire irq_a_o,
    input wire pin_a_o,
    input wire pin_b_o,
    input wire pin_a_oe_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire port_wr = req && wb_we_i && wb_adr_i[5:2] == 4'h7 && wb_sel_i[0];
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
    property p_ack_resp;
        req |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered next cycle");
    property p_ack_idle;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_dat_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data not zero outside ack");
    property p_oe_write;
        port_wr |-> ##2 pin_a_oe_o == $past(wb_dat_i[2], 2);
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("pin enable does not follow direction bit");
    property p_oe_cause;
        $changed(pin_a_oe_o) |-> $past(port_wr, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin enable changed without port write");
    property p_irq_clear;
        irq_ack_a_i && presc_tick_i == 7'h00 && $stable(ext_pin_i) ##1 presc_tick_i == 7'h00 && $stable(ext_pin_i)
            |-> ##1 !irq_a_o;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("serviced match interrupt still high");
    property p_pin_reset;
        $fell(rst_i) |-> !pin_a_o && !pin_b_o && !pin_a_oe_o;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin outputs not cleared by reset");
endmodule
bind tmc_timer tmc_timer_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .presc_tick_i(presc_tick_i), .ext_pin_i(ext_pin_i), .irq_ack_a_i(irq_ack_a_i),
    .irq_a_o(irq_a_o), .pin_a_o(pin_a_o), .pin_b_o(pin_b_o), .pin_a_oe_o(pin_a_oe_o));
